// ### hw/fasc_pkg.sv
// Function
// - each channel record is 32 bytes, packed
// - region base/end follows configured channel count
// - three-bit voice format code decode, rest reserved
// - recent period N recomputes every N+1 packets
// - table offset gives state table bits 20:12
// - signed correction added before table indexing
// - hardware keeps largest local/remote energy seen
// - zero recent tally means recent max is -78
// - silent padding energy taken from tracked maximum
// - hardware fields kept apart from software fields
package fasc_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] FASC_CFG_ADDR = 8'h00;
    localparam logic [7:0] FASC_CORR_ADDR = 8'h04;
    localparam logic [7:0] FASC_ENERGY_ADDR = 8'h08;
    localparam logic [7:0] FASC_STATUS_ADDR = 8'h0C;
    localparam logic [7:0] FASC_CHAN_ADDR = 8'h10;
    localparam logic [7:0] FASC_RECADDR_ADDR = 8'h14;
    localparam logic [5:0] FASC_PKTCNT_IDX = 6'h1E;
    localparam logic [7:0] FASC_PKTCNT_ADDR = {FASC_PKTCNT_IDX, 2'b00};

    // ----------------------------------------
    // field layouts
    // ----------------------------------------
    localparam int FASC_CFG_FMT_LSB = 0;
    localparam int FASC_CFG_PERIOD_LSB = 4;
    localparam int FASC_CFG_TOFS_LSB = 8;
    localparam int FASC_CFG_CNTSEL_LSB = 17;
    localparam int FASC_EN_MAXREM_LSB = 8;
    localparam int FASC_EN_RECENT_LSB = 16;
    localparam int FASC_EN_PAD_LSB = 24;

    // ----------------------------------------
    // record region and energy scale
    // ----------------------------------------
    localparam int FASC_REC_BYTES = 32;
    localparam int FASC_REC_SHIFT = 5;
    localparam logic [15:0] FASC_BASE_128 = 16'h1000;
    localparam logic [15:0] FASC_BASE_256 = 16'h2000;
    localparam logic [15:0] FASC_BASE_512 = 16'h4000;
    localparam logic [15:0] FASC_BASE_1023 = 16'h8000;
    localparam logic [9:0] FASC_MAXCH_128 = 10'h07F;
    localparam logic [9:0] FASC_MAXCH_256 = 10'h0FF;
    localparam logic [9:0] FASC_MAXCH_512 = 10'h1FF;
    localparam logic [9:0] FASC_MAXCH_1023 = 10'h3FF;
    localparam logic [6:0] FASC_ENERGY_FLOOR = 7'h4E;
    localparam logic [6:0] FASC_ENERGY_TOP = 7'h00;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [31:0] FASC_CFG_RESET = 32'h0000_0000;
    localparam logic [15:0] FASC_CORR_RESET = 16'h0000;

    typedef enum logic [2:0] {
        FASC_FMT_PCM = 3'h0,
        FASC_FMT_ADPCM_40K = 3'h1,
        FASC_FMT_ADPCM_32K = 3'h2,
        FASC_FMT_ADPCM_24K = 3'h3,
        FASC_FMT_ADPCM_16K = 3'h4,
        FASC_FMT_PCM_MISALIGNED = 3'h5
    } fasc_fmt_e;

    localparam logic [1:0] FASC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FASC_RESP_SLVERR = 2'h2;

endpackage

// ### hw/fasc_final_assembly_ctx.sv
`timescale 1ns/1ps
`default_nettype none
module fasc_final_assembly_ctx
    import fasc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // measured energy stream from the assembly path
    input wire logic energy_valid_i,
    input wire logic energy_remote_i,
    input wire logic [6:0] energy_i,
    input wire logic packet_end_i,
    // state table lookup, decoded format and record address
    output logic [20:0] table_addr_o,
    output logic table_addr_valid_o,
    output logic [2:0] voice_format_code_o,
    output logic format_adpcm_o,
    output logic format_reserved_o,
    output logic [15:0] record_addr_o
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [2:0] fmt_reg;
    logic [3:0] period_reg;
    logic [8:0] tofs_reg;
    logic [1:0] cntsel_reg;
    logic [7:0] corr_local_reg;
    logic [7:0] corr_remote_reg;
    logic [6:0] max_local_reg;
    logic [6:0] max_remote_reg;
    logic [6:0] recent_max_reg;
    logic [6:0] pad_reg;
    logic [3:0] recent_packet_tally_reg;
    logic [6:0] pkt_local_reg;
    logic [9:0] chan_reg;
    logic [15:0] pkt_count_reg;

    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    function automatic logic [6:0] louder(input logic [6:0] a,
                                          input logic [6:0] b);
        louder = (a < b) ? a : b;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // ----------------------------------------
    // format decode
    // ----------------------------------------
    logic fmt_known;
    always_comb begin
        fmt_known = 1'b1;
        unique case (fmt_reg)
            FASC_FMT_PCM, FASC_FMT_ADPCM_40K, FASC_FMT_ADPCM_32K,
            FASC_FMT_ADPCM_24K, FASC_FMT_ADPCM_16K,
            FASC_FMT_PCM_MISALIGNED: fmt_known = 1'b1;
            default: fmt_known = 1'b0;
        endcase
    end
    assign voice_format_code_o = fmt_reg;
    assign format_reserved_o = ~fmt_known;
    assign format_adpcm_o = fmt_known && (fmt_reg != FASC_FMT_PCM) &&
                            (fmt_reg != FASC_FMT_PCM_MISALIGNED);

    // ----------------------------------------
    // record placement
    // ----------------------------------------
    logic [15:0] rec_base;
    logic [9:0] rec_max;
    logic [9:0] chan_eff;
    always_comb begin
        unique case (cntsel_reg)
            2'h0: begin
                rec_base = FASC_BASE_128;
                rec_max = FASC_MAXCH_128;
            end
            2'h1: begin
                rec_base = FASC_BASE_256;
                rec_max = FASC_MAXCH_256;
            end
            2'h2: begin
                rec_base = FASC_BASE_512;
                rec_max = FASC_MAXCH_512;
            end
            default: begin
                rec_base = FASC_BASE_1023;
                rec_max = FASC_MAXCH_1023;
            end
        endcase
        // out-of-range channels pin to the last record of the region
        chan_eff = (chan_reg > rec_max) ? rec_max : chan_reg;
    end
    // 32-byte records back to back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            record_addr_o <= 16'h0000;
        end else if (ce_i) begin
            record_addr_o <= rec_base +
                ({6'h00, chan_eff} << FASC_REC_SHIFT);
        end
    end

    // ----------------------------------------
    // energy correction and table lookup
    // ----------------------------------------
    logic [7:0] corr_sel;
    logic signed [8:0] corr_sum;
    logic [6:0] corr_idx;
    // reserved formats are never processed; sample_ok drops samples while fmt_known is low
    logic sample_ok;
    assign sample_ok = energy_valid_i && fmt_known;
    always_comb begin
        corr_sel = energy_remote_i ? corr_remote_reg : corr_local_reg;
        corr_sum = $signed({2'b00, energy_i}) +
                   $signed({corr_sel[7], corr_sel});
        if (corr_sum < 0) begin
            corr_idx = FASC_ENERGY_TOP;
        end else if (corr_sum > $signed({2'b00, FASC_ENERGY_FLOOR})) begin
            corr_idx = FASC_ENERGY_FLOOR;
        end else begin
            corr_idx = corr_sum[6:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_addr_o <= 21'h000000;
            table_addr_valid_o <= 1'b0;
        end else if (ce_i) begin
            table_addr_valid_o <= sample_ok;
            if (sample_ok) begin
                table_addr_o <= {tofs_reg, 4'h0, energy_remote_i,
                                 corr_idx};
            end
        end
    end

    // ----------------------------------------
    // axi write path
    // ----------------------------------------
    logic do_write;
    logic [31:0] wval;
    assign s_axi_awready_o = ce_i && !aw_full_reg;
    assign s_axi_wready_o = ce_i && !w_full_reg;
    assign do_write = ce_i && aw_full_reg && w_full_reg && !bvalid_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= FASC_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid_i && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                unique case ({aw_addr_reg[7:2], 2'b00})
                    FASC_CFG_ADDR, FASC_CORR_ADDR, FASC_ENERGY_ADDR,
                    FASC_STATUS_ADDR, FASC_CHAN_ADDR, FASC_RECADDR_ADDR,
                    FASC_PKTCNT_ADDR: bresp_reg <= FASC_RESP_OKAY;
                    default: bresp_reg <= FASC_RESP_SLVERR;
                endcase
            end else if (s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    logic wr_cfg;
    logic wr_corr;
    logic wr_energy;
    logic wr_chan;
    always_comb begin
        wr_cfg = do_write && (aw_addr_reg[7:2] == FASC_CFG_ADDR[7:2]);
        wr_corr = do_write && (aw_addr_reg[7:2] == FASC_CORR_ADDR[7:2]);
        wr_energy = do_write &&
                    (aw_addr_reg[7:2] == FASC_ENERGY_ADDR[7:2]);
        wr_chan = do_write && (aw_addr_reg[7:2] == FASC_CHAN_ADDR[7:2]);
    end

    logic [31:0] cfg_word;
    logic [31:0] corr_word;
    logic [31:0] energy_word;
    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[FASC_CFG_FMT_LSB +: 3] = fmt_reg;
        cfg_word[FASC_CFG_PERIOD_LSB +: 4] = period_reg;
        cfg_word[FASC_CFG_TOFS_LSB +: 9] = tofs_reg;
        cfg_word[FASC_CFG_CNTSEL_LSB +: 2] = cntsel_reg;
        corr_word = {16'h0000, corr_remote_reg, corr_local_reg};
        energy_word = 32'h0000_0000;
        energy_word[6:0] = max_local_reg;
        energy_word[FASC_EN_MAXREM_LSB +: 7] = max_remote_reg;
        energy_word[FASC_EN_RECENT_LSB +: 7] = recent_max_reg;
        energy_word[FASC_EN_PAD_LSB +: 7] = pad_reg;
    end
    assign wval = merge(wr_corr ? corr_word : wr_chan ?
                        {22'h000000, chan_reg} : cfg_word,
                        w_data_reg, w_strb_reg);

    // ---- software configuration fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fmt_reg <= FASC_CFG_RESET[FASC_CFG_FMT_LSB +: 3];
            period_reg <= FASC_CFG_RESET[FASC_CFG_PERIOD_LSB +: 4];
            tofs_reg <= FASC_CFG_RESET[FASC_CFG_TOFS_LSB +: 9];
            cntsel_reg <= FASC_CFG_RESET[FASC_CFG_CNTSEL_LSB +: 2];
            corr_local_reg <= FASC_CORR_RESET[7:0];
            corr_remote_reg <= FASC_CORR_RESET[15:8];
            chan_reg <= 10'h000;
        end else if (ce_i) begin
            if (wr_cfg) begin
                fmt_reg <= wval[FASC_CFG_FMT_LSB +: 3];
                period_reg <= wval[FASC_CFG_PERIOD_LSB +: 4];
                tofs_reg <= wval[FASC_CFG_TOFS_LSB +: 9];
                cntsel_reg <= wval[FASC_CFG_CNTSEL_LSB +: 2];
            end
            if (wr_corr) begin
                {corr_remote_reg, corr_local_reg} <= wval[15:0];
            end
            if (wr_chan) begin
                chan_reg <= wval[9:0];
            end
        end
    end

    // ----------------------------------------
    // hardware-tracked energies
    // ----------------------------------------
    logic local_hit;
    logic remote_hit;
    logic [6:0] cur_pkt;
    logic [6:0] recent_eff;
    logic [6:0] recent_new;
    logic [31:0] ew;
    always_comb begin
        local_hit = sample_ok && !energy_remote_i;
        remote_hit = sample_ok && energy_remote_i;
        cur_pkt = local_hit ? louder(pkt_local_reg, energy_i)
                            : pkt_local_reg;
        // a fresh period starts from silence, not from stale contents
        recent_eff = (recent_packet_tally_reg == 4'h0) ?
                     FASC_ENERGY_FLOOR : recent_max_reg;
        recent_new = louder(recent_eff, cur_pkt);
        ew = merge(energy_word, w_data_reg, w_strb_reg);
    end

    // ---- software may clear max fields; a same-cycle sample still counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            max_local_reg <= FASC_ENERGY_FLOOR;
            max_remote_reg <= FASC_ENERGY_FLOOR;
        end else if (ce_i) begin
            if (wr_energy && local_hit) begin
                max_local_reg <= louder(ew[6:0], energy_i);
            end else if (wr_energy) begin
                max_local_reg <= ew[6:0];
            end else if (local_hit) begin
                max_local_reg <= louder(max_local_reg, energy_i);
            end
            if (wr_energy && remote_hit) begin
                max_remote_reg <= louder(ew[FASC_EN_MAXREM_LSB +: 7],
                                         energy_i);
            end else if (wr_energy) begin
                max_remote_reg <= ew[FASC_EN_MAXREM_LSB +: 7];
            end else if (remote_hit) begin
                max_remote_reg <= louder(max_remote_reg, energy_i);
            end
        end
    end

    // ---- recent period bookkeeping; these fields ignore bus writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pkt_local_reg <= FASC_ENERGY_FLOOR;
            recent_max_reg <= FASC_ENERGY_FLOOR;
            recent_packet_tally_reg <= 4'h0;
            pad_reg <= FASC_ENERGY_FLOOR;
            pkt_count_reg <= 16'h0000;
        end else if (ce_i) begin
            if (packet_end_i) begin
                pkt_local_reg <= FASC_ENERGY_FLOOR;
                pkt_count_reg <= pkt_count_reg + 16'h0001;
                recent_max_reg <= recent_new;
                if (recent_packet_tally_reg >= period_reg) begin
                    pad_reg <= recent_new;
                    recent_packet_tally_reg <= 4'h0;
                end else begin
                    recent_packet_tally_reg <=
                        recent_packet_tally_reg + 4'h1;
                end
            end else begin
                pkt_local_reg <= cur_pkt;
            end
        end
    end

    // ----------------------------------------
    // axi read path
    // ----------------------------------------
    logic [31:0] rmux;
    logic rhit;
    always_comb begin
        rmux = 32'h0000_0000;
        rhit = 1'b1;
        unique case ({s_axi_araddr_i[7:2], 2'b00})
            FASC_CFG_ADDR: rmux = cfg_word;
            FASC_CORR_ADDR: rmux = corr_word;
            FASC_ENERGY_ADDR: rmux = energy_word;
            FASC_STATUS_ADDR: rmux = {24'h000000, ~fmt_known, 3'h0,
                                      recent_packet_tally_reg};
            FASC_CHAN_ADDR: rmux = {22'h000000, chan_reg};
            FASC_RECADDR_ADDR: rmux = {16'h0000, record_addr_o};
            FASC_PKTCNT_ADDR: rmux = {16'h0000, pkt_count_reg};
            default: rhit = 1'b0;
        endcase
    end
    assign s_axi_arready_o = ce_i && !rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= FASC_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid_i && !rvalid_reg) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rmux;
                rresp_reg <= rhit ? FASC_RESP_OKAY : FASC_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### sim/fasc_ctx_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fasc_ctx_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic energy_valid_i,
    input wire logic energy_remote_i,
    input wire logic [20:0] table_addr_o,
    input wire logic table_addr_valid_o,
    input wire logic [2:0] voice_format_code_o,
    input wire logic format_adpcm_o,
    input wire logic format_reserved_o,
    input wire logic [15:0] record_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    // a frozen block (ce_i low) takes nothing, so leave it out
    assign take = ce_i && energy_valid_i && !format_reserved_o;

    chk_lookup_follows: assert property (take |=> table_addr_valid_o
        && table_addr_o[7] == $past(energy_remote_i))
        else $error("lookup missing after accepted sample");
    chk_reserved_refused: assert property (ce_i && energy_valid_i
        && format_reserved_o |=> !table_addr_valid_o)
        else $error("sample taken under reserved format");
    chk_index_clamped: assert property (table_addr_valid_o
        |-> table_addr_o[6:0] <= 7'h4E && table_addr_o[11:8] == 4'h0)
        else $error("table index out of range");
    chk_adpcm_decode: assert property (format_adpcm_o ==
        (voice_format_code_o inside {[3'h1:3'h4]}))
        else $error("adpcm decode wrong");
    chk_reserved_decode: assert property (format_reserved_o ==
        (voice_format_code_o >= 3'h6))
        else $error("reserved decode wrong");
    chk_record_align: assert property (record_addr_o[4:0] == 5'h00)
        else $error("record address not on 32 byte step");
    chk_record_region: assert property (record_addr_o == 16'h0000
        || record_addr_o >= 16'h1000)
        else $error("record address below region");
    chk_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    chk_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");

    cov_lookup: cover property (take ##1 table_addr_valid_o);
    cov_clamp_top: cover property (table_addr_valid_o
        && table_addr_o[6:0] == 7'h4E);
    cov_refused: cover property (energy_valid_i && format_reserved_o);
endmodule

bind fasc_final_assembly_ctx fasc_ctx_chk u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .energy_valid_i(energy_valid_i),
    .energy_remote_i(energy_remote_i), .table_addr_o(table_addr_o),
    .table_addr_valid_o(table_addr_valid_o),
    .voice_format_code_o(voice_format_code_o),
    .format_adpcm_o(format_adpcm_o),
    .format_reserved_o(format_reserved_o), .record_addr_o(record_addr_o));
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fasc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
    logic energy_valid_i = 1'b0, energy_remote_i = 1'b0, packet_end_i = 1'b0;
    logic [6:0] energy_i = 7'h00;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, table_addr_valid_o, format_adpcm_o;
    logic format_reserved_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [20:0] table_addr_o;
    logic [2:0] voice_format_code_o;
    logic [15:0] record_addr_o;
    logic [15:0] base [4] = '{16'h1000, 16'h2000, 16'h4000, 16'h8000};
    logic [15:0] last [4] = '{16'h1FE0, 16'h3FE0, 16'h7FE0, 16'hFFE0};
    int en [5] = '{10, 1, 78, 40, 78};
    int co [5] = '{1, -2, 1, 49, -78};
    logic rm [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    int n_mismatch = 0, num_checks = 0;

    always #5 clk_i = ~clk_i;

    fasc_final_assembly_ctx DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .energy_valid_i(energy_valid_i),
        .energy_remote_i(energy_remote_i), .energy_i(energy_i),
        .packet_end_i(packet_end_i), .table_addr_o(table_addr_o),
        .table_addr_valid_o(table_addr_valid_o),
        .voice_format_code_o(voice_format_code_o),
        .format_adpcm_o(format_adpcm_o), .format_reserved_o(format_reserved_o),
        .record_addr_o(record_addr_o));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // outputs read right at the edge still show the pre-edge values;
    // bready/rready come late on purpose so the slave must hold its answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk_i);
            if (!aw_d && s_axi_awready_o === 1'b1) begin
                aw_d = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w_d && s_axi_wready_o === 1'b1) begin
                w_d = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b1;
        @(posedge clk_i);
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b1;
        @(posedge clk_i);
        rd = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic sample(input logic r, input logic [6:0] e, input logic pe,
                          input logic v, input logic [20:0] ea);
        energy_valid_i <= 1'b1;
        energy_remote_i <= r;
        energy_i <= e;
        packet_end_i <= pe;
        @(posedge clk_i);
        energy_valid_i <= 1'b0;
        packet_end_i <= 1'b0;
        @(posedge clk_i);
        check("lookup_vld", 32'(table_addr_valid_o), 32'(v));
        if (v) check("lookup_addr", 32'(table_addr_o), 32'(ea));
    endtask

    function automatic logic [20:0] exp_addr(input logic r, input int e, c);
        int s;
        s = e + c;
        if (s < 0) s = 0;
        if (s > 78) s = 78;
        return {9'h1A5, 4'h0, r, 7'(s)};
    endfunction

    task automatic chk_rp(input int pad, input int rec);
        axi_rd(FASC_ENERGY_ADDR);
        check("pad", 32'(rd[30:24]), 32'(pad));
        check("recent", 32'(rd[22:16]), 32'(rec));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        axi_rd(FASC_ENERGY_ADDR);
        check("energy_rst", rd, 32'h4E4E_4E4E);
        axi_rd(8'hFC);
        check("unmapped_rd", {rd[29:0], resp}, 32'h2);
        axi_wr(8'hFC, 32'h1);
        check("unmapped_wr", 32'(resp), 32'(FASC_RESP_SLVERR));
        for (int c = 0; c < 8; c++) begin
            axi_wr(FASC_CFG_ADDR, 32'(c));
            check("fmt", 32'(voice_format_code_o), 32'(c));
            check("adpcm", 32'(format_adpcm_o), 32'(c > 0 && c < 5));
            check("rsvd", 32'(format_reserved_o), 32'(c > 5));
        end
        sample(1'b0, 7'h05, 1'b0, 1'b0, 21'h0);
        axi_rd(FASC_ENERGY_ADDR);
        check("rsvd_energy", rd, 32'h4E4E_4E4E);
        for (int s = 0; s < 4; s++) begin
            axi_wr(FASC_CFG_ADDR, 32'(s) << 17);
            axi_wr(FASC_CHAN_ADDR, 32'h3);
            check("rec_3", 32'(record_addr_o), 32'(base[s] + 16'h60));
            axi_wr(FASC_CHAN_ADDR, 32'h3FF);
            check("rec_end", 32'(record_addr_o), 32'(last[s]));
            axi_rd(FASC_RECADDR_ADDR);
            check("recaddr", rd, 32'(last[s]));
        end
        axi_wr(FASC_CFG_ADDR, 32'h0001_A500);
        for (int i = 0; i < 5; i++) begin
            axi_wr(FASC_CORR_ADDR, 32'(8'(co[i])) << (rm[i] ? 8 : 0));
            sample(rm[i], 7'(en[i]), 1'b0, 1'b1,
                   exp_addr(rm[i], en[i], co[i]));
        end
        axi_rd(FASC_ENERGY_ADDR);
        check("max_energy", rd, 32'h4E4E_010A);
        axi_wr(FASC_ENERGY_ADDR, 32'h1234_4E4E);
        axi_rd(FASC_ENERGY_ADDR);
        check("hw_fields_kept", rd, 32'h4E4E_4E4E);
        axi_wr(FASC_STATUS_ADDR, 32'hF);
        axi_rd(FASC_STATUS_ADDR);
        check("status_ro", rd, 32'h0);
        sample(1'b0, 7'd20, 1'b1, 1'b1, exp_addr(1'b0, 20, 0));
        chk_rp(10, 10);
        axi_wr(FASC_CFG_ADDR, 32'h0001_A510);
        axi_wr(FASC_ENERGY_ADDR, 32'h4E4E);
        sample(1'b0, 7'd30, 1'b1, 1'b1, exp_addr(1'b0, 30, 0));
        chk_rp(10, 30);
        axi_rd(FASC_STATUS_ADDR);
        check("tally", 32'(rd[3:0]), 32'h1);
        sample(1'b0, 7'd40, 1'b1, 1'b1, exp_addr(1'b0, 40, 0));
        chk_rp(30, 30);
        axi_rd(FASC_STATUS_ADDR);
        check("tally", 32'(rd[3:0]), 32'h0);
        axi_wr(FASC_ENERGY_ADDR, 32'h4E4E);
        sample(1'b0, 7'd50, 1'b1, 1'b1, exp_addr(1'b0, 50, 0));
        chk_rp(30, 50);
        axi_rd(FASC_PKTCNT_ADDR);
        check("pkt_count", 32'(rd[15:0]), 32'h4);
        complete_run();
    end

    // the sequence needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
